// File: pwm_buf_pkg.sv
package pwm_buf_pkg;

  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] FREE_TOP = 16'hffff;
  localparam logic [15:0] FREE_PRE = 16'hfffe;
  localparam logic [1:0] CLK_SEL_OFF = 2'h0;

  typedef enum logic {
    MODE_EDGE,
    MODE_CENTER
  } pwm_mode_type;

  // byte-pair write coherency: which half is still missing
  typedef enum logic [1:0] {
    PAIR_EMPTY,
    PAIR_LOW_SEEN,
    PAIR_HIGH_SEEN,
    PAIR_FULL
  } pair_type;

  // byte write request toward a 16-bit register
  typedef struct packed {
    logic wr_low;
    logic wr_high;
    logic [7:0] data;
  } byte_wr_type;

  // configuration seen by the counter and channel
  typedef struct packed {
    pwm_mode_type mode;
    logic [1:0] counter_clock_source_select;
    logic polarity_high;
  } pwm_cfg_type;

endpackage : pwm_buf_pkg

// File: pair_buffer.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// two-byte write buffer with coherency tracking
// ------------------------------------------------------------
module pair_buffer
  import pwm_buf_pkg::*;
(
  input wire logic i_clk,                    // system clock
  input wire logic i_rst_n,                  // sync reset, active low
  input wire logic i_ce,                     // clock enable
  input wire byte_wr_type i_wr,              // byte writes
  input wire logic i_clear,                  // drop half-written pair
  input wire logic i_take,                   // full pair consumed
  output logic [15:0] o_value,               // buffered value
  output logic o_full                        // both bytes written
);

  typedef struct packed {
    pair_type pair;
    logic [15:0] value;
  } state_type;

  state_type state;
  state_type next_state;

  always_comb begin
    next_state = state;
    if (i_take) begin
      next_state.pair = PAIR_EMPTY;
    end
    if (i_clear) begin
      next_state.pair = PAIR_EMPTY;
    end
    if (i_wr.wr_low) begin
      next_state.value[7:0] = i_wr.data;
      next_state.pair = (next_state.pair == PAIR_HIGH_SEEN ||
                         next_state.pair == PAIR_FULL) ?
                        PAIR_FULL : PAIR_LOW_SEEN;
    end
    if (i_wr.wr_high) begin
      next_state.value[15:8] = i_wr.data;
      next_state.pair = (next_state.pair == PAIR_LOW_SEEN ||
                         next_state.pair == PAIR_FULL) ?
                        PAIR_FULL : PAIR_HIGH_SEEN;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= '{pair: PAIR_EMPTY, value: CNT_ZERO};
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  assign o_value = state.value;
  assign o_full = (state.pair == PAIR_FULL);

endmodule : pair_buffer

// File: pwm_duty_buffer_update.sv
`timescale 1ns/1ps

// Function
// - edge mode, clock on: load after both bytes, counter mod-1 to mod
// - center mode, clock on: load after both bytes, counter mod-1 to mod
// - free-running counter: load happens as counter steps fffe to ffff
// - center mode, channel value equal modulo gives full duty
// - center mode, channel value modulo minus one gives near-full duty
// - center mode, zero to nonzero takes effect at next period start
// - center mode, nonzero to zero finishes current period with old duty
// - debug halt plus status/control write clears modulo byte-pair state
// - center counts up to modulo, then down (free-running counts up only); set on down, clear on up
// - edge period is modulo plus one, 65536 when modulo is 0; compare clears output; polarity chosen
module pwm_duty_buffer_update
  import pwm_buf_pkg::*;
#(
  parameter int WIDTH = CNT_W               // counter width
) (
  input wire logic i_clk,                    // 125 MHz system clock
  input wire logic i_rst_n,                  // sync reset, active low
  input wire logic i_ce,                     // clock enable, freezes all
  input wire logic i_count_tick,             // prescaled counter step
  input wire pwm_cfg_type i_cfg,             // mode, clock select, polarity
  input wire byte_wr_type i_chan_wr,         // channel value byte writes
  input wire byte_wr_type i_mod_wr,          // modulo byte writes
  input wire logic i_status_control_wr,      // timer_status_control write
  input wire logic i_background_debug_halt,  // cpu halted in debug
  output logic [15:0] o_counter,             // current counter
  output logic [15:0] o_channel_compare_value, // active compare value
  output logic [15:0] o_counter_modulo_value,  // active modulo
  output logic o_pwm,                        // channel output
  output logic o_period_start                // one-cycle period start
);

  typedef struct packed {
    logic [15:0] counter;
    logic count_down;
    logic [15:0] compare;
    logic [15:0] modulo;
    logic active;
    logic period_start;
  } state_type;

  state_type state;
  state_type next_state;

  logic [15:0] chan_buf;
  logic chan_full;
  logic [15:0] mod_buf;
  logic mod_full;
  logic clock_on;
  logic free_run;
  logic [15:0] top;
  logic [15:0] top_m1;
  logic step;
  logic load_point;
  logic chan_take;
  logic mod_take;
  logic mod_clear;
  logic [15:0] cnt_after;
  logic down_after;

  // ------------------------------------------------------------
  // write buffers
  // ------------------------------------------------------------
  pair_buffer chan_buffer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_wr(i_chan_wr),
    .i_clear(i_status_control_wr),
    .i_take(chan_take),
    .o_value(chan_buf),
    .o_full(chan_full)
  );

  pair_buffer mod_buffer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_wr(i_mod_wr),
    .i_clear(mod_clear),
    .i_take(mod_take),
    .o_value(mod_buf),
    .o_full(mod_full)
  );

  // debug halt with control write drops half-written modulo
  assign mod_clear = i_background_debug_halt &&
                     i_status_control_wr;

  // ------------------------------------------------------------
  // counter and load point
  // ------------------------------------------------------------
  assign clock_on = (i_cfg.counter_clock_source_select != CLK_SEL_OFF);
  assign free_run = (state.modulo == CNT_ZERO) ||
                    (state.modulo == FREE_TOP);
  assign top = free_run ? FREE_TOP : state.modulo;
  assign top_m1 = top - CNT_ONE;
  assign step = clock_on && i_count_tick && !i_background_debug_halt;

  always_comb begin
    cnt_after = state.counter;
    down_after = state.count_down;
    if (i_cfg.mode == MODE_CENTER && !free_run) begin
      // up to modulo, down to zero
      if (!state.count_down) begin
        if (state.counter >= top) begin
          down_after = 1'b1;
          cnt_after = state.counter - CNT_ONE;
        end else begin
          cnt_after = state.counter + CNT_ONE;
        end
      end else if (state.counter == CNT_ZERO) begin
        down_after = 1'b0;
        cnt_after = CNT_ONE;
      end else begin
        cnt_after = state.counter - CNT_ONE;
      end
    end else begin
      // period of top plus one counts; top is ffff when free-running
      down_after = 1'b0;
      cnt_after = (state.counter >= top) ? CNT_ZERO :
                  state.counter + CNT_ONE;
    end
  end

  // update only on the mod-1 to mod step
  assign load_point = step && !state.count_down &&
                      state.counter == top_m1 &&
                      cnt_after == top;
  // clock off loads directly, but must still empty the pair
  assign chan_take = (load_point || !clock_on) &&
                     chan_full;
  assign mod_take = (load_point || !clock_on) && mod_full;

  // ------------------------------------------------------------
  // state update and output
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.period_start = 1'b0;
    if (step) begin
      next_state.counter = cnt_after;
      next_state.count_down = down_after;
      next_state.period_start = (cnt_after == CNT_ZERO) &&
                                (i_cfg.mode == MODE_EDGE);
      if (i_cfg.mode == MODE_CENTER) begin
        if (!state.count_down && state.counter == top_m1 &&
            state.compare == top_m1) begin
          // match at mod-1 going up leaves it at its current level
          next_state.active = state.active;
        end
        if (down_after && cnt_after == state.compare) begin
          next_state.active = 1'b1;
        end else if (!down_after && cnt_after == state.compare &&
                     state.compare != top) begin
          next_state.active = 1'b0;
        end
        if (state.compare == CNT_ZERO) begin
          next_state.active = 1'b0;
        end
        // period runs top to top, so a load there starts it
        if (!state.count_down && cnt_after == top) begin
          next_state.period_start = 1'b1;
        end
      end else begin
        if (cnt_after == CNT_ZERO) begin
          next_state.active = (state.compare != CNT_ZERO);
        end
        if (cnt_after == state.compare) begin
          next_state.active = 1'b0;
        end
      end
    end
    if (i_cfg.mode == MODE_CENTER && state.compare == top) begin
      next_state.active = 1'b1;
    end
    // new compare is used only from the load point, which the edge
    // period boundary follows and the center one shares; old duty finishes this period
    if (chan_take) begin
      next_state.compare = chan_buf;
    end
    if (mod_take) begin
      next_state.modulo = mod_buf;
    end
    if (!clock_on) begin
      // no clock source: registers update directly
      if (chan_full) begin
        next_state.compare = chan_buf;
      end
      if (mod_full) begin
        next_state.modulo = mod_buf;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= '{counter: CNT_ZERO, count_down: 1'b0,
                 compare: CNT_ZERO, modulo: CNT_ZERO,
                 active: 1'b0, period_start: 1'b0};
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  assign o_counter = state.counter;
  assign o_channel_compare_value = state.compare;
  assign o_counter_modulo_value = state.modulo;
  assign o_pwm = state.active ~^ i_cfg.polarity_high;
  assign o_period_start = state.period_start;

endmodule : pwm_duty_buffer_update

// File: pwm_duty_buffer_update_checker.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// port checks
// ------------------------------------------------------------
module pwm_duty_checker
  import pwm_buf_pkg::*;
(
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // reset, active low
  input wire pwm_cfg_type i_cfg, // configuration
  input wire logic i_background_debug_halt, // debug halt
  input wire logic [15:0] o_counter, // counter
  input wire logic [15:0] o_channel_compare_value, // compare
  input wire logic [15:0] o_counter_modulo_value, // modulo
  input wire logic o_pwm, // output
  input wire logic o_period_start // period pulse
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic [1:0] sel = i_cfg.counter_clock_source_select;
  wire logic [15:0] md = o_counter_modulo_value;
  wire logic [15:0] cv = o_channel_compare_value;
  wire logic lim = md != CNT_ZERO && md != FREE_TOP;
  wire logic ctr = i_cfg.mode == MODE_CENTER;
  a_load_at_top: assert property (
    sel != 0 && $past(sel) != 0 &&
    $changed(cv) |-> o_counter == $past(o_counter) + 16'h0001 &&
    (o_counter == md || o_counter == FREE_TOP)) else $error("late load");
  a_halt_stops: assert property (i_background_debug_halt
    |=> $stable(o_counter)) else $error("counted in halt");
  a_off_stops: assert property (sel == CLK_SEL_OFF
    |=> $stable(o_counter)) else $error("counted with clock off");
  a_edge_wrap: assert property (!ctr && o_period_start
    |-> o_counter == CNT_ZERO) else $error("period start off zero");
  a_edge_top: assert property (!ctr && lim && $stable(md) &&
    $changed(o_counter) && $past(o_counter) == md |-> o_counter == CNT_ZERO)
    else $error("no wrap at modulo");
  a_center_turn: assert property (ctr && lim && $stable(md) &&
    $changed(o_counter) && $past(o_counter) == md |-> o_counter == md - 1)
    else $error("no turn at modulo");
  a_full_duty: assert property ((ctr && lim && cv == md) [*2]
    |-> o_pwm == i_cfg.polarity_high) else $error("not full duty");
  a_edge_zero: assert property ((!ctr && cv == CNT_ZERO) [*2]
    |-> o_pwm == !i_cfg.polarity_high) else $error("zero duty active");
  a_pulse_one: assert property (o_period_start
    |=> !o_period_start) else $error("long period pulse");
endmodule : pwm_duty_checker

// File: pwm_load_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// load: active and total cycles per period
// ------------------------------------------------------------
module pwm_load_model (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // reset, active low
  input wire logic i_pwm, // channel output
  input wire logic i_pol, // active level
  input wire logic i_start, // period start
  output logic [16:0] o_on, // active cycles
  output logic [16:0] o_len // period cycles
);
  logic [16:0] on_acc;
  logic [16:0] len_acc;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      {o_on, o_len, on_acc, len_acc} <= '0;
    end else if (i_start) begin
      o_on <= on_acc;
      o_len <= len_acc;
      on_acc <= 17'(i_pwm == i_pol);
      len_acc <= 17'h00001;
    end else begin
      on_acc <= on_acc + 17'(i_pwm == i_pol);
      len_acc <= len_acc + 17'h00001;
    end
  end
endmodule : pwm_load_model

// File: test_pwm_duty_buffer_update.sv
`timescale 1ns/1ps

module test_pwm_duty_buffer_update
  import pwm_buf_pkg::*;
;
  logic clk = 0, rst_n = 0, ce = 1, tick = 1, scw = 0, halt = 0;
  pwm_cfg_type cfg = '{MODE_EDGE, 2'h0, 1'b1};
  byte_wr_type cw = '0, mw = '0;
  logic [15:0] cnt, cmp, mdl;
  logic pwm, ps;
  logic [16:0] on, len;
  int mismatches = 0, total_checks = 0;
  always #4 clk = ~clk;
  pwm_duty_buffer_update u_pwm_duty_buffer_update (.i_clk(clk),
    .i_rst_n(rst_n), .i_ce(ce), .i_count_tick(tick), .i_cfg(cfg),
    .i_chan_wr(cw), .i_mod_wr(mw), .i_status_control_wr(scw),
    .i_background_debug_halt(halt), .o_counter(cnt),
    .o_channel_compare_value(cmp), .o_counter_modulo_value(mdl),
    .o_pwm(pwm), .o_period_start(ps));
  pwm_load_model u_pwm_load_model (.i_clk(clk), .i_rst_n(rst_n),
    .i_pwm(pwm), .i_pol(cfg.polarity_high), .i_start(ps), .o_on(on),
    .o_len(len));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [16:0] s, e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cy
  task automatic wb(input bit m, input bit hi, input logic [7:0] d);
    if (m) mw = '{!hi, hi, d};
    else cw = '{!hi, hi, d};
    cy(1);
    mw = '0;
    cw = '0;
    cy(1);
  endtask : wb
  task automatic wr(input bit m, input logic [15:0] v);
    wb(m, 0, v[7:0]);
    wb(m, 1, v[15:8]);
  endtask : wr
  task automatic wt(input bit w, input int n);
    logic [15:0] old;
    int i;
    old = cmp;
    for (i = 0; i < n && (w ? ps !== 1'b1 : cmp === old); i++) cy(1);
    if (i == n) begin
      chk("wait", 0, 1);
      tally_and_finish;
    end
    if (w) cy(1);
  endtask : wt
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_edge;
    wr(1, 16'h0009);
    wr(0, 16'h0006);
    cy(2);
    chk("mod", mdl, 16'h0009);
    cfg.counter_clock_source_select = 2'h1;
    wr(0, 16'h0003);
    wt(0, 40);
    chk("load cnt", cnt, 16'h0009);
    chk("cmp", cmp, 16'h0003);
    wt(1, 40);
    wt(1, 40);
    chk("on", on, 17'h00003);
    chk("len", len, 17'h0000a);
  endtask : t_edge
  task automatic t_center;
    cfg = '{MODE_CENTER, 2'h0, 1'b1};
    wr(0, 16'h0009);
    cy(2);
    cfg.counter_clock_source_select = 2'h1;
    wt(1, 60);
    wt(1, 60);
    chk("full", on, len);
    chk("len", len, 17'h00012);
    wr(0, 16'h0008);
    wt(0, 60);
    chk("load cnt", cnt, 16'h0009);
    wt(1, 60);
    wt(1, 60);
    chk("near", on > 0 && on < len, 1);
  endtask : t_center
  task automatic t_zero;
    wr(0, 16'h0000);
    wt(0, 60);
    wt(1, 60);
    chk("old duty", on != 0, 1);
    wt(1, 60);
    chk("zero", on, 0);
    wr(0, 16'h0004);
    wt(0, 60);
    wt(1, 60);
    chk("wait period", on, 0);
    wt(1, 60);
    chk("new duty", on != 0, 1);
  endtask : t_zero
  task automatic t_halt;
    cfg.counter_clock_source_select = 2'h0;
    halt = 1;
    wb(1, 0, 8'h05);
    scw = 1;
    cy(1);
    scw = 0;
    wb(1, 1, 8'h00);
    cy(2);
    chk("half pair", mdl, 16'h0009);
    wb(1, 0, 8'h05);
    cy(2);
    chk("pair", mdl, 16'h0005);
    halt = 0;
  endtask : t_halt
  task automatic t_free;
    cfg = '{MODE_EDGE, 2'h0, 1'b1};
    wr(1, 16'h0000);
    cy(2);
    cfg.counter_clock_source_select = 2'h1;
    wr(0, 16'h1234);
    wt(0, 70000);
    chk("free top", cnt, FREE_TOP);
  endtask : t_free
  initial begin
    cy(5);
    rst_n = 1;
    t_edge;
    t_center;
    t_zero;
    t_halt;
    t_free;
    tally_and_finish;
  end
endmodule : test_pwm_duty_buffer_update

bind pwm_duty_buffer_update pwm_duty_checker u_pwm_duty_checker (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg(i_cfg),
  .i_background_debug_halt(i_background_debug_halt),
  .o_counter(o_counter), .o_channel_compare_value(o_channel_compare_value),
  .o_counter_modulo_value(o_counter_modulo_value), .o_pwm(o_pwm),
  .o_period_start(o_period_start));
